// ### alu_consts.svh
`ifndef ALU_CONSTS_SVH
`define ALU_CONSTS_SVH

// system clocks in one instruction cycle
`define CLKS_PER_INSTR 4
`define LAST_PHASE 2'h3

// data memory address of the low program counter byte
`define PC_LOW_ADDR 8'h06
// the only data memory sector these operations may reach
`define SECTOR_ZERO 3'h0

// reset values
`define ACC_RST 8'h00
`define FLAGS_RST 6'h00

// decimal adjust thresholds and corrections
`define BCD_MAX_DIGIT 4'h9
`define BCD_LO_FIX 9'h006
`define BCD_HI_FIX 9'h060

`endif

// ### alu_pkg.sv
package alu_pkg;

  typedef enum logic [4:0] {
    OP_ADD = 5'h00,
    OP_ADC = 5'h01,
    OP_SUB = 5'h02,
    OP_SUBTRACT_WITH_BORROW = 5'h03,
    OP_DECIMAL_ADJUST = 5'h04,
    OP_AND = 5'h05,
    OP_OR = 5'h06,
    OP_XOR = 5'h07,
    OP_COMPLEMENT = 5'h08,
    OP_INCREMENT = 5'h09,
    OP_DECREMENT = 5'h0a,
    OP_ROT_RIGHT = 5'h0b,
    OP_ROT_LEFT = 5'h0c,
    OP_ROT_RIGHT_CARRY = 5'h0d,
    OP_ROT_LEFT_CARRY = 5'h0e,
    OP_BIT_SET = 5'h0f,
    OP_BIT_CLEAR = 5'h10
  } alu_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_EXTRA = 3'b100
  } ctl_state_t;

  typedef struct packed {
    logic z;
    logic c;
    logic aux_carry_flag;
    logic overflow_flag;
    logic signed_carry_flag;
    logic compare_zero_flag;
  } flags_t;

  typedef struct packed {
    alu_op_t op;
    logic src_imm;
    logic dst_mem;
    logic [2:0] sector;
    logic [7:0] addr;
    logic [7:0] imm;
    logic [7:0] mdata;
    logic [2:0] bit_idx;
  } req_t;

  typedef struct packed {
    ctl_state_t st;
    logic [1:0] phase;
    req_t req;
    logic [7:0] acc;
    flags_t fl;
    logic mem_we;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic busy;
    logic done;
    logic reject;
  } alu_state_t;

endpackage : alu_pkg

// ### mcu_alu.sv
// Contract
// RULE1: add memory or immediate to acc, with or without carry; five flags
// RULE2: add-to-memory forms write acc plus location back to that location
// RULE3: subtract immediate from acc in one cycle; six flags
// RULE4: subtract-to-memory form updates the same six flags
// RULE5: subtract with borrow for immediate, memory and memory destination
// RULE6: decimal adjust acc, store in memory, change only carry
// RULE7: carry catches sums above 255; borrow when difference below 0
// RULE8: and, or, xor with memory into acc; zero flag only
// RULE9: memory-destination and, or, xor; zero flag only
// RULE10: and, or, xor with immediate into acc; zero flag only
// RULE11: zero flag set exactly when a logic result is zero
// RULE12: complement memory byte to memory or acc; zero flag only
// RULE13: increment memory byte to memory or acc; zero flag only
// RULE14: decrement memory byte to memory or acc; zero flag only
// RULE15: plain rotates by one position leave all flags alone
// RULE16: rotates through carry swap the edge bit and carry; carry only
// RULE17: bit set and clear change one bit, others kept
// RULE18: memory operands only in data memory sector 0
// RULE19: one instruction cycle is four system clocks
// RULE20: writing the low program counter byte costs one extra cycle
// RULE21: aux carry from bit 3 to 4; overflow on signed overflow
// RULE22: 8-bit values, results wrap modulo 256, carry keeps lost bit
`timescale 1ns/100ps
`include "alu_consts.svh"

module mcu_alu
  import alu_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // request from decoder
  input wire logic req_valid,
  input wire req_t req,
  // accumulator and status
  output logic [7:0] accumulator_reg,
  output flags_t flags,
  // data memory write port
  output logic mem_we,
  output logic [7:0] mem_waddr,
  output logic [7:0] mem_wdata,
  // handshake
  output logic busy,
  output logic done,
  output logic reject
);

  localparam alu_state_t RST_S = '{
    st: ST_IDLE,
    phase: 2'h0,
    req: '0,
    acc: `ACC_RST,
    fl: `FLAGS_RST,
    mem_we: 1'b0,
    waddr: 8'h00,
    wdata: 8'h00,
    busy: 1'b0,
    done: 1'b0,
    reject: 1'b0
  };

  alu_state_t s;
  alu_state_t next_s;

  // operation classes
  function automatic logic is_arith(input alu_op_t op);
    is_arith = (op == OP_ADD) || (op == OP_ADC) || (op == OP_SUB)
      || (op == OP_SUBTRACT_WITH_BORROW);
  endfunction : is_arith

  function automatic logic is_logic(input alu_op_t op);
    is_logic = (op == OP_AND) || (op == OP_OR) || (op == OP_XOR);
  endfunction : is_logic

  // ops that always land in memory, whatever dst_mem says
  function automatic logic forced_mem(input alu_op_t op);
    forced_mem = (op == OP_DECIMAL_ADJUST) || (op == OP_BIT_SET) || (op == OP_BIT_CLEAR);
  endfunction : forced_mem

  function automatic logic to_memory(input req_t r);
    to_memory = r.dst_mem || forced_mem(r.op);
  endfunction : to_memory

  // an immediate is only a second operand aimed at the acc
  function automatic logic bad_request(input req_t r);
    logic mem_used;
    logic imm_misuse;
    mem_used = !r.src_imm || to_memory(r);
    imm_misuse = r.src_imm && (to_memory(r) || !(is_arith(r.op) || is_logic(r.op)));
    bad_request = imm_misuse || (mem_used && (r.sector != `SECTOR_ZERO)); // see RULE18
  endfunction : bad_request

  // datapath, evaluated from the captured request
  logic [7:0] opnd;
  logic [7:0] opnd2;
  logic sub_op;
  logic cin;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [8:0] bcd1;
  logic bcd_hi;
  logic [8:0] bcd2;
  logic [7:0] bit_mask;
  logic [7:0] res;
  flags_t nf;

  always_comb begin
    opnd = s.req.src_imm ? s.req.imm : s.req.mdata; // see RULE10
    sub_op = (s.req.op == OP_SUB) || (s.req.op == OP_SUBTRACT_WITH_BORROW);
    // subtract as acc + ~m + 1, or + carry when borrowing
    opnd2 = sub_op ? ~opnd : opnd; // see RULE5
    case (s.req.op)
      OP_ADC: cin = s.fl.c;
      OP_SUB: cin = 1'b1;
      OP_SUBTRACT_WITH_BORROW: cin = s.fl.c;
      default: cin = 1'b0;
    endcase
    sum9 = {1'b0, s.acc} + {1'b0, opnd2} + {8'h00, cin}; // see RULE22
    nib5 = {1'b0, s.acc[3:0]} + {1'b0, opnd2[3:0]} + {4'h0, cin}; // see RULE21
    bcd1 = {1'b0, s.acc};
    if ((s.acc[3:0] > `BCD_MAX_DIGIT) || s.fl.aux_carry_flag) begin
      bcd1 = {1'b0, s.acc} + `BCD_LO_FIX;
    end
    bcd_hi = bcd1[8] || s.fl.c || (bcd1[7:4] > `BCD_MAX_DIGIT);
    bcd2 = bcd_hi ? (bcd1 + `BCD_HI_FIX) : bcd1;
    bit_mask = 8'h01 << s.req.bit_idx;
    nf = s.fl;
    res = opnd;
    case (s.req.op)
      OP_ADD, OP_ADC, OP_SUB, OP_SUBTRACT_WITH_BORROW: begin
        res = sum9[7:0];
        // carry doubles as not-borrow on subtraction
        nf.c = sum9[8]; // see RULE7
        nf.aux_carry_flag = nib5[4]; // see RULE21
        nf.overflow_flag = (s.acc[7] == opnd2[7]) && (sum9[7] != s.acc[7]); // see RULE21
        nf.signed_carry_flag = nf.overflow_flag ^ sum9[7];
        nf.z = (sum9[7:0] == 8'h00); // see RULE1
        if (s.req.op == OP_SUB) begin
          nf.compare_zero_flag = nf.z; // see RULE3
        end else if (s.req.op == OP_SUBTRACT_WITH_BORROW) begin
          // chained compare over multi-byte subtraction
          nf.compare_zero_flag = nf.z && s.fl.compare_zero_flag; // see RULE5
        end
      end
      OP_DECIMAL_ADJUST: begin
        res = bcd2[7:0];
        nf.c = s.fl.c || bcd_hi; // see RULE6
      end
      OP_AND: begin
        res = s.acc & opnd;
        nf.z = ((s.acc & opnd) == 8'h00); // see RULE11
      end
      OP_OR: begin
        res = s.acc | opnd;
        nf.z = ((s.acc | opnd) == 8'h00); // see RULE11
      end
      OP_XOR: begin
        res = s.acc ^ opnd;
        nf.z = ((s.acc ^ opnd) == 8'h00); // see RULE11
      end
      OP_COMPLEMENT: begin
        res = ~opnd;
        nf.z = (opnd == 8'hff); // see RULE12
      end
      OP_INCREMENT: begin
        res = opnd + 8'h01;
        nf.z = (opnd == 8'hff); // see RULE13
      end
      OP_DECREMENT: begin
        res = opnd - 8'h01;
        nf.z = (opnd == 8'h01); // see RULE14
      end
      OP_ROT_RIGHT: res = {opnd[0], opnd[7:1]}; // see RULE15
      OP_ROT_LEFT: res = {opnd[6:0], opnd[7]}; // see RULE15
      OP_ROT_RIGHT_CARRY: begin
        res = {s.fl.c, opnd[7:1]};
        nf.c = opnd[0]; // see RULE16
      end
      OP_ROT_LEFT_CARRY: begin
        res = {opnd[6:0], s.fl.c};
        nf.c = opnd[7]; // see RULE16
      end
      OP_BIT_SET: res = opnd | bit_mask; // see RULE17
      OP_BIT_CLEAR: res = opnd & ~bit_mask; // see RULE17
      default: res = opnd;
    endcase
  end

  // control: accept, four-clock instruction cycle, optional extra cycle
  logic pc_low_dest;
  logic last_phase;

  always_comb begin
    pc_low_dest = to_memory(s.req) && (s.req.addr == `PC_LOW_ADDR);
    last_phase = (s.phase == `LAST_PHASE);
    next_s = s;
    // a low clk_en holds everything, pulses included
    if (clk_en) begin
      next_s.mem_we = 1'b0;
      next_s.done = 1'b0;
      next_s.reject = 1'b0;
      case (s.st)
        ST_IDLE: begin
          if (req_valid) begin
            if (bad_request(req)) begin
              next_s.reject = 1'b1; // see RULE18
            end else begin
              next_s.req = req;
              next_s.st = ST_EXEC;
              next_s.phase = 2'h0;
              next_s.busy = 1'b1;
            end
          end
        end
        ST_EXEC: begin
          next_s.phase = s.phase + 2'h1; // see RULE19
          if (last_phase) begin
            if (pc_low_dest) begin
              next_s.st = ST_EXTRA; // see RULE20
            end else begin
              next_s.st = ST_IDLE;
              next_s.busy = 1'b0;
              next_s.done = 1'b1;
              next_s.fl = nf; // see RULE4
              if (to_memory(s.req)) begin
                next_s.mem_we = 1'b1; // see RULE2
                next_s.waddr = s.req.addr;
                next_s.wdata = res; // see RULE9
              end else begin
                next_s.acc = res; // see RULE8
              end
            end
          end
        end
        ST_EXTRA: begin
          next_s.phase = s.phase + 2'h1;
          // commit held back so flags and the memory write land together; acc is left as it is
          if (last_phase) begin
            next_s.st = ST_IDLE;
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
            next_s.fl = nf;
            next_s.mem_we = 1'b1; // see RULE20
            next_s.waddr = s.req.addr;
            next_s.wdata = res;
          end
        end
        default: next_s = RST_S;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= RST_S;
    end else begin
      s <= next_s;
    end
  end

  assign accumulator_reg = s.acc;
  assign flags = s.fl;
  assign mem_we = s.mem_we;
  assign mem_waddr = s.waddr;
  assign mem_wdata = s.wdata;
  assign busy = s.busy;
  assign done = s.done;
  assign reject = s.reject;

  // checking: enabled edges since the request was taken
  logic [3:0] edge_cnt;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      edge_cnt <= 4'h0;
    end else if (clk_en && s.st == ST_IDLE) begin
      edge_cnt <= 4'h0;
    end else if (clk_en) begin
      edge_cnt <= edge_cnt + 4'h1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!rst_n);

  a_instr_length: assert property ( // see RULE19
    done && !$past(pc_low_dest) |-> edge_cnt == 4'h4)
    else $error("instruction cycle not four clocks");

  a_pc_low_extra: assert property ( // see RULE20
    done && $past(pc_low_dest) |-> edge_cnt == 4'h8 && mem_we && mem_waddr == `PC_LOW_ADDR)
    else $error("low program counter write not two cycles");

  // rising edge only: a stalled done would compare against committed values
  a_add_result: assert property ( // see RULE1
    $rose(done) && s.req.op == OP_ADD && !s.req.dst_mem
    |-> {flags.c, accumulator_reg} == {1'b0, $past(s.acc)} + {1'b0, $past(opnd)})
    else $error("add result or carry wrong");

  a_sub_borrow: assert property ( // see RULE7
    $rose(done) && s.req.op == OP_SUB
    |-> flags.c == ($past(s.acc) >= $past(opnd)) && flags.compare_zero_flag == flags.z)
    else $error("subtract borrow or compare flag wrong");

  a_logic_zero: assert property ( // see RULE11
    $rose(done) && is_logic(s.req.op) && !s.req.dst_mem
    |-> flags.z == (accumulator_reg == 8'h00)
    && flags[4:0] == $past(s.fl[4:0]))
    else $error("logic op flags wrong");

  a_rotate_flags: assert property ( // see RULE15
    $rose(done) && (s.req.op == OP_ROT_RIGHT || s.req.op == OP_ROT_LEFT)
    |-> flags == $past(flags))
    else $error("plain rotate touched flags");

  a_adjust_carry_only: assert property ( // see RULE6
    $rose(done) && s.req.op == OP_DECIMAL_ADJUST
    |-> mem_we && accumulator_reg == $past(accumulator_reg)
    && {flags.z, flags[3:0]} == {$past(flags.z), $past(flags[3:0])})
    else $error("decimal adjust changed more than carry");

  a_bit_write: assert property ( // see RULE17
    done && s.req.op == OP_BIT_SET
    |-> mem_we && mem_wdata == (s.req.mdata | (8'h01 << s.req.bit_idx)))
    else $error("bit set changed other bits");

  a_sector_refused: assert property ( // see RULE18
    clk_en && !busy && req_valid && !req.src_imm && req.sector != `SECTOR_ZERO
    |=> reject && !busy)
    else $error("foreign sector request not refused");

  c_add_to_mem: cover property (done && s.req.op == OP_ADD && mem_we);
  c_borrow_chain: cover property (done && s.req.op == OP_SUBTRACT_WITH_BORROW
    && flags.compare_zero_flag);
  c_pc_low_write: cover property (done && mem_waddr == `PC_LOW_ADDR);
  c_rotate_carry: cover property (done && s.req.op == OP_ROT_LEFT_CARRY && flags.c);

endmodule : mcu_alu

// ### alu_mem_model.sv
`timescale 1ns/100ps
module alu_mem_model (
  // clock
  input wire logic clk,
  input wire logic clk_en,
  // write port from the alu
  input wire logic mem_we,
  input wire logic [7:0] mem_waddr,
  input wire logic [7:0] mem_wdata
);
  logic [7:0] mem [256];
  // arbitrary fill so that reads see varied bytes
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i * 37 + 5);
    end
  end
  // a stalled pulse writes only once, since the write waits for clk_en
  always @(posedge clk) begin
    if (mem_we && clk_en) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end
endmodule : alu_mem_model

// ### tb_mcu_alu.sv
`timescale 1ns/100ps
`include "alu_consts.svh"
module tb_mcu_alu;
  import alu_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic req_valid = 1'b0;
  req_t rq = '0;
  logic [7:0] acc_o, wa_o, wd_o;
  flags_t fl_o;
  logic we_o, busy_o, done_o, rej_o;
  int n_mismatch = 0;
  int n_checks = 0;
  logic [31:0] lfsr = 32'hd34d;
  int m_acc = 0;
  logic [5:0] m_fl = 6'h00;
  req_t r;
  // predictions wait here from acceptance until the commit
  int exp_q[$];

  always #50 clk = ~clk;

  mcu_alu dut_u (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .req_valid(req_valid), .req(rq),
    .accumulator_reg(acc_o), .flags(fl_o), .mem_we(we_o), .mem_waddr(wa_o),
    .mem_wdata(wd_o), .busy(busy_o), .done(done_o), .reject(rej_o));
  alu_mem_model mem_u (.clk(clk), .clk_en(clk_en), .mem_we(we_o), .mem_waddr(wa_o),
    .mem_wdata(wd_o));

  function automatic int rnd();
    lfsr = {lfsr[30:0], ^(lfsr & 32'h80200003)};
    return int'(lfsr[30:0]);
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic step();
    @(posedge clk);
    #2;
  endtask

  // flags packed zero, carry, aux, overflow, signed, compare; msb first
  function automatic void ref_op(input alu_op_t op, input int a, m, bi, input logic [5:0] f,
                                 output int res, output logic [5:0] nf);
    int m2, cin, t;
    logic c;
    c = f[4];
    nf = f;
    res = 0;
    case (op)
      OP_ADD, OP_ADC, OP_SUB, OP_SUBTRACT_WITH_BORROW: begin
        m2 = (op inside {OP_SUB, OP_SUBTRACT_WITH_BORROW}) ? (~m & 255) : m;
        cin = (op == OP_ADD) ? 0 : (op == OP_SUB) ? 1 : c;
        t = a + m2 + cin;
        res = t & 255;
        nf[4] = t > 255;
        nf[3] = ((a & 15) + (m2 & 15) + cin) > 15;
        nf[2] = (a[7] == m2[7]) && (res[7] != a[7]);
        nf[1] = nf[2] ^ res[7];
        nf[5] = res == 0;
        if (op == OP_SUB) nf[0] = nf[5];
        if (op == OP_SUBTRACT_WITH_BORROW) nf[0] = nf[5] & f[0];
      end
      OP_DECIMAL_ADJUST: begin
        t = a + (((a & 15) > 9 || f[3]) ? 6 : 0);
        c = c || t > 255 || ((t >> 4) & 15) > 9;
        res = (t + (c ? 96 : 0)) & 255;
        nf[4] = c;
      end
      OP_AND: res = a & m;
      OP_OR: res = a | m;
      OP_XOR: res = a ^ m;
      OP_COMPLEMENT: res = ~m & 255;
      OP_INCREMENT: res = (m + 1) & 255;
      OP_DECREMENT: res = (m - 1) & 255;
      OP_ROT_RIGHT: res = (m >> 1) | ((m & 1) << 7);
      OP_ROT_LEFT: res = ((m << 1) | (m >> 7)) & 255;
      OP_ROT_RIGHT_CARRY: begin
        res = (m >> 1) | (c << 7);
        nf[4] = m[0];
      end
      OP_ROT_LEFT_CARRY: begin
        res = ((m << 1) | c) & 255;
        nf[4] = m[7];
      end
      OP_BIT_SET: res = m | (1 << bi);
      default: res = m & ~(1 << bi) & 255;
    endcase
    if (op >= OP_AND && op <= OP_DECREMENT) nf[5] = res == 0;
  endfunction

  function automatic req_t legal(input int op);
    req_t q;
    q = '0;
    q.op = alu_op_t'(op);
    q.addr = 8'(rnd() & 15);
    q.imm = 8'(rnd());
    q.bit_idx = 3'(rnd());
    q.dst_mem = (rnd() & 1) || op inside {4, 15, 16};
    q.src_imm = !q.dst_mem && op inside {[0:3], [5:7]} && (rnd() & 1);
    return q;
  endfunction

  task automatic run(input req_t q, input bit rej);
    int res, lat, n, k;
    logic [5:0] nf;
    logic mdst, en;
    q.mdata = mem_u.mem[q.addr];
    rq = q;
    req_valid = 1'b1;
    clk_en = 1'b1;
    step();
    req_valid = 1'b0;
    if (rej) begin
      chk("reject", 1, rej_o);
      chk("busy", 0, busy_o);
      step();
      chk("acc kept", m_acc, acc_o);
      chk("flags kept", m_fl, fl_o);
      return;
    end
    mdst = q.dst_mem || q.op inside {OP_DECIMAL_ADJUST, OP_BIT_SET, OP_BIT_CLEAR};
    lat = (mdst && q.addr == `PC_LOW_ADDR) ? 8 : 4;
    ref_op(q.op, m_acc, q.src_imm ? q.imm : q.mdata, q.bit_idx, m_fl, res, nf);
    exp_q.push_back(res);
    n = 0;
    k = 0;
    // busy must ignore whatever the decoder shows meanwhile
    while (done_o !== 1'b1 && k < 100) begin
      chk("busy", 1, busy_o);
      en = (rnd() & 3) != 0;
      clk_en = en;
      req_valid = 1'(rnd());
      rq.op = alu_op_t'(rnd() & 7);
      step();
      n += en;
      k++;
    end
    req_valid = 1'b0;
    rq = q;
    chk("latency", lat, n);
    chk("done", 1, done_o);
    chk("busy at done", 0, busy_o);
    chk("no reject", 0, rej_o);
    res = exp_q.pop_front();
    if (mdst) begin
      chk("mem_we", 1, we_o);
      chk("waddr", q.addr, wa_o);
      chk("wdata", res, wd_o);
    end else begin
      m_acc = res;
      chk("mem_we", 0, we_o);
    end
    m_fl = nf;
    chk("acc", m_acc, acc_o);
    chk("flags", m_fl, fl_o);
    // let the write land before the next read of memory
    if (mdst) begin
      clk_en = 1'b1;
      step();
    end
  endtask

  initial begin
    repeat (4) step();
    rst_n = 1'b1;
    chk("acc rst", 0, acc_o);
    chk("flags rst", 0, fl_o);
    chk("busy rst", 0, busy_o);
    chk("done rst", 0, done_o);
    chk("we rst", 0, we_o);
    chk("reject rst", 0, rej_o);
    step();
    for (int op = 0; op < 17; op++) run(legal(op), 0);
    repeat (300) run(legal(rnd() % 17), 0);
    // reset in mid-instruction must drop the pending commit
    rq = legal(1);
    req_valid = 1'b1;
    clk_en = 1'b1;
    step();
    req_valid = 1'b0;
    step();
    rst_n = 1'b0;
    step();
    rst_n = 1'b1;
    m_acc = 0;
    m_fl = 6'h00;
    chk("busy mid rst", 0, busy_o);
    chk("acc mid rst", m_acc, acc_o);
    chk("flags mid rst", m_fl, fl_o);
    step();
    chk("done mid rst", 0, done_o);
    chk("we mid rst", 0, we_o);
    r = legal(0);
    r.dst_mem = 1'b1;
    r.src_imm = 1'b0;
    r.addr = `PC_LOW_ADDR;
    run(r, 0);
    r.sector = 3'h1;
    run(r, 1);
    r = legal(5);
    r.dst_mem = 1'b1;
    r.src_imm = 1'b1;
    run(r, 1);
    r = legal(8);
    r.dst_mem = 1'b0;
    r.src_imm = 1'b1;
    run(r, 1);
    wrap_up();
  end

  initial begin
    #5000000;
    n_mismatch++;
    wrap_up();
  end
endmodule : tb_mcu_alu
